/* tsmc_map.svh */
// register map, field positions, command codes and reset values of the thermal sensor control block
`ifndef TSMC_MAP_SVH
`define TSMC_MAP_SVH
`define TSMC_OWN_ADDR 7'h4e
`define TSMC_RSV_ADDR_A 7'h2a
`define TSMC_RSV_ADDR_B 7'h2b
`define TSMC_CFG_RESET 8'h00
`define TSMC_CFG_MASK_BIT 7
`define TSMC_CFG_STBY_BIT 6
`define TSMC_CFG_WR_MASK 8'hc0
`define TSMC_CMD_TEMP_RD 8'h00
`define TSMC_CMD_ITEMP_RD 8'h01
`define TSMC_CMD_CFG_RD 8'h03
`define TSMC_CMD_CFG_WR 8'h09
`define TSMC_CMD_ONE_SHOT 8'h0f
`define TSMC_RD_UNMAPPED 8'hff
`define TSMC_CONV_CYCLES 4000
`endif

/* tsmc_pkg.sv */
// types of the thermal sensor control block
package tsmc_pkg;
  typedef enum logic [3:0] {
    TSMC_ST_IDLE = 4'b0000,
    TSMC_ST_ADDR = 4'b0001,
    TSMC_ST_ADDR_ACK = 4'b0010,
    TSMC_ST_CMD = 4'b0011,
    TSMC_ST_CMD_ACK = 4'b0100,
    TSMC_ST_WDATA = 4'b0101,
    TSMC_ST_WDATA_ACK = 4'b0110,
    TSMC_ST_RDATA = 4'b0111,
    TSMC_ST_RDATA_ACK = 4'b1000,
    TSMC_ST_IGNORE = 4'b1001
  } tsmc_state_e;

  typedef struct packed {
    tsmc_state_e st;
    logic scl_prev;
    logic sda_prev;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic rw;
    logic [7:0] cmd;
    logic sda_oe;
    logic [7:0] cfg;
    logic busy;
    logic [15:0] conv_cnt;
    logic [7:0] diode_temp;
    logic [7:0] int_temp;
    logic alert;
  } tsmc_state_s;
endpackage

/* tsmc_sensor.sv */
// thermal sensor control: smbus target, configuration register, conversion mode control and alert
`timescale 1ns/1ps
`include "tsmc_map.svh"
module tsmc_sensor
  import tsmc_pkg::*;
#(
  parameter int CONV_CYCLES = `TSMC_CONV_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  output logic alert_n_out,
  output logic alert_oe_out,
  input wire logic [7:0] diode_temp_in,
  input wire logic [7:0] internal_temp_in,
  input wire logic [7:0] upper_limit_in,
  input wire logic [7:0] lower_limit_in,
  output logic conv_busy_out,
  output logic standby_out
);

  tsmc_state_s s_reg;
  tsmc_state_s s_next;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic [7:0] byte_in;
  logic one_shot_hit;
  logic out_of_range;
  logic [7:0] rd_byte;

  function automatic logic beyond(input logic [7:0] t, input logic [7:0] hi, input logic [7:0] lo);
    beyond = (t > hi) || (t < lo);
  endfunction

  function automatic logic [7:0] read_byte(input tsmc_state_s s);
    case (s.cmd)
      `TSMC_CMD_TEMP_RD: read_byte = s.diode_temp;
      `TSMC_CMD_ITEMP_RD: read_byte = s.int_temp;
      `TSMC_CMD_CFG_RD: read_byte = s.cfg;
      default: read_byte = `TSMC_RD_UNMAPPED;
    endcase
  endfunction

  // a select straight on a function call is refused by strict front ends
  assign rd_byte = read_byte(s_reg);
  assign scl_rise = !s_reg.scl_prev && scl_in;
  assign scl_fall = s_reg.scl_prev && !scl_in;
  assign start_seen = s_reg.scl_prev && scl_in && s_reg.sda_prev && !sda_in;
  assign stop_seen = s_reg.scl_prev && scl_in && !s_reg.sda_prev && sda_in;
  assign byte_in = {s_reg.shreg[6:0], sda_in};
  // equality is not treated as beyond; the limits allow either
  assign out_of_range = beyond(s_reg.diode_temp, upper_limit_in, lower_limit_in) ||
                        beyond(s_reg.int_temp, upper_limit_in, lower_limit_in);
  // one-shot arrives as a send-byte, acted on when its acknowledge is released
  assign one_shot_hit = (s_reg.st == TSMC_ST_CMD_ACK) && scl_fall && s_reg.sda_oe &&
                        (s_reg.cmd == `TSMC_CMD_ONE_SHOT);

  always_comb begin
    s_next = s_reg;
    s_next.scl_prev = scl_in;
    s_next.sda_prev = sda_in;
    if (start_seen) begin
      s_next.st = TSMC_ST_ADDR;
      s_next.bitcnt = 4'h0;
      s_next.sda_oe = 1'b0;
    end else if (stop_seen) begin
      s_next.st = TSMC_ST_IDLE;
      s_next.sda_oe = 1'b0;
    end else begin
      unique case (s_reg.st)
        TSMC_ST_IDLE, TSMC_ST_IGNORE: begin
          s_next.sda_oe = 1'b0;
        end
        TSMC_ST_ADDR, TSMC_ST_CMD, TSMC_ST_WDATA: begin
          if (scl_rise) begin
            s_next.shreg = byte_in;
            s_next.bitcnt = s_reg.bitcnt + 4'h1;
            if (s_reg.bitcnt == 4'h7) begin
              s_next.bitcnt = 4'h0;
              if (s_reg.st == TSMC_ST_ADDR) begin
                s_next.rw = byte_in[0];
                if (byte_in[7:1] == `TSMC_OWN_ADDR && byte_in[7:1] != `TSMC_RSV_ADDR_A &&
                    byte_in[7:1] != `TSMC_RSV_ADDR_B) begin
                  s_next.st = TSMC_ST_ADDR_ACK;
                end else begin
                  s_next.st = TSMC_ST_IGNORE;
                end
              end else if (s_reg.st == TSMC_ST_CMD) begin
                s_next.cmd = byte_in;
                s_next.st = TSMC_ST_CMD_ACK;
              end else begin
                if (s_reg.cmd == `TSMC_CMD_CFG_WR) begin
                  // reserved bits are not stored and read back as zero
                  s_next.cfg = byte_in & `TSMC_CFG_WR_MASK;
                end
                s_next.st = TSMC_ST_WDATA_ACK;
              end
            end
          end
        end
        TSMC_ST_ADDR_ACK, TSMC_ST_CMD_ACK, TSMC_ST_WDATA_ACK: begin
          if (scl_fall) begin
            if (!s_reg.sda_oe) begin
              s_next.sda_oe = 1'b1;
            end else begin
              s_next.sda_oe = 1'b0;
              s_next.bitcnt = 4'h0;
              if (s_reg.st == TSMC_ST_ADDR_ACK && s_reg.rw) begin
                s_next.st = TSMC_ST_RDATA;
                s_next.sda_oe = !rd_byte[7];
                s_next.shreg = {rd_byte[6:0], 1'b0};
                s_next.bitcnt = 4'h1;
              end else if (s_reg.st == TSMC_ST_ADDR_ACK) begin
                s_next.st = TSMC_ST_CMD;
              end else if (s_reg.st == TSMC_ST_CMD_ACK) begin
                s_next.st = TSMC_ST_WDATA;
              end else begin
                s_next.st = TSMC_ST_IGNORE;
              end
            end
          end
        end
        TSMC_ST_RDATA: begin
          if (scl_fall) begin
            if (s_reg.bitcnt == 4'h8) begin
              s_next.sda_oe = 1'b0;
              s_next.st = TSMC_ST_RDATA_ACK;
            end else begin
              s_next.sda_oe = !s_reg.shreg[7];
              s_next.shreg = {s_reg.shreg[6:0], 1'b0};
              s_next.bitcnt = s_reg.bitcnt + 4'h1;
            end
          end
        end
        TSMC_ST_RDATA_ACK: begin
          // single-byte reads only; the master's answer is not needed
          if (scl_rise) begin
            s_next.st = TSMC_ST_IGNORE;
          end
        end
        default: begin
          s_next.st = TSMC_ST_IDLE;
          s_next.sda_oe = 1'b0;
        end
      endcase
    end

    // conversion engine
    if (s_reg.busy) begin
      if (s_reg.conv_cnt == 16'(CONV_CYCLES - 1)) begin
        s_next.busy = 1'b0;
        s_next.diode_temp = diode_temp_in;
        s_next.int_temp = internal_temp_in;
      end else begin
        s_next.conv_cnt = s_reg.conv_cnt + 16'h1;
      end
    end else if (!s_reg.cfg[`TSMC_CFG_STBY_BIT]) begin
      s_next.busy = 1'b1;
      s_next.conv_cnt = 16'h0;
    end else if (one_shot_hit) begin
      // in auto-convert the command is dropped; the host must not count on it
      s_next.busy = 1'b1;
      s_next.conv_cnt = 16'h0;
    end
    if (s_next.cfg[`TSMC_CFG_STBY_BIT] && !s_reg.cfg[`TSMC_CFG_STBY_BIT]) begin
      s_next.busy = 1'b0;
    end

    s_next.alert = !s_reg.cfg[`TSMC_CFG_MASK_BIT] && out_of_range;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_reg <= '{st: TSMC_ST_IDLE, scl_prev: 1'b1, sda_prev: 1'b1, bitcnt: 4'h0, shreg: 8'h00, rw: 1'b0,
                 cmd: 8'h00, sda_oe: 1'b0, cfg: `TSMC_CFG_RESET, busy: 1'b0, conv_cnt: 16'h0,
                 diode_temp: 8'h00, int_temp: 8'h00, alert: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe_out = s_reg.sda_oe;
  assign alert_n_out = 1'b0;
  assign alert_oe_out = s_reg.alert;
  assign conv_busy_out = s_reg.busy;
  assign standby_out = s_reg.cfg[`TSMC_CFG_STBY_BIT];

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  a_addr_match: assert property ((s_reg.st == TSMC_ST_ADDR_ACK && $past(s_reg.st) == TSMC_ST_ADDR)
    |-> s_reg.shreg[7:1] == `TSMC_OWN_ADDR) else $error("acknowledged a foreign address");
  a_rsv_addr_quiet: assert property ((s_reg.st == TSMC_ST_ADDR_ACK && $past(s_reg.st) == TSMC_ST_ADDR)
    |-> (s_reg.shreg[7:1] != `TSMC_RSV_ADDR_A && s_reg.shreg[7:1] != `TSMC_RSV_ADDR_B))
    else $error("acknowledged a reserved address");
  a_auto_restart: assert property ((!s_reg.cfg[`TSMC_CFG_STBY_BIT] && !s_reg.busy)
    |=> (s_reg.busy || s_reg.cfg[`TSMC_CFG_STBY_BIT])) else $error("auto-convert did not restart");
  a_standby_stop: assert property ($rose(s_reg.cfg[`TSMC_CFG_STBY_BIT]) |-> !s_reg.busy)
    else $error("conversion kept running into standby");
  a_one_shot_run: assert property ((s_reg.cfg[`TSMC_CFG_STBY_BIT] && one_shot_hit && !s_reg.busy)
    |=> s_reg.busy ##1 s_reg.busy) else $error("one-shot did not start a conversion");
  a_mask_alert: assert property (s_reg.cfg[`TSMC_CFG_MASK_BIT] ##1 s_reg.cfg[`TSMC_CFG_MASK_BIT]
    |-> !alert_oe_out) else $error("alert driven while masked");
  a_rsv_bits_zero: assert property (s_reg.cfg[5:0] == 6'h00)
    else $error("reserved configuration bits not zero");
  a_alert_drive: assert property ((!s_reg.cfg[`TSMC_CFG_MASK_BIT] && out_of_range)
    |=> alert_oe_out) else $error("unmasked out-of-range alert missing");

  c_auto_done: cover property (s_reg.busy ##1 !s_reg.busy);
  c_one_shot: cover property (s_reg.cfg[`TSMC_CFG_STBY_BIT] && one_shot_hit);
  c_cfg_read: cover property (s_reg.st == TSMC_ST_RDATA && s_reg.cmd == `TSMC_CMD_CFG_RD);
  c_alert: cover property ($rose(alert_oe_out));

endmodule // tsmc_sensor

/* tsmc_host.sv */
// smbus host controller model that drives the sensor bus
`timescale 1ns/1ps
module tsmc_host (
  input wire logic clk_in,
  input wire logic sda_oe_in,
  output logic scl_out,
  output logic sda_out
);
  logic drv = 1'b1;
  initial scl_out = 1'b1;
  // the pulled-up wire reads high wherever nobody pulls it low
  assign sda_out = drv & ~sda_oe_in;
  task automatic hold(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // 3 clk phases keep the 2 clk minimum with margin
  task automatic bit_io(input logic b, output logic r);
    drv <= b;
    hold(3);
    scl_out <= 1'b1;
    hold(2);
    r = sda_out;
    hold(1);
    scl_out <= 1'b0;
    hold(3);
  endtask
  task automatic start;
    drv <= 1'b1;
    hold(3);
    scl_out <= 1'b1;
    hold(3);
    drv <= 1'b0;
    hold(3);
    scl_out <= 1'b0;
    hold(3);
  endtask
  task automatic stop;
    drv <= 1'b0;
    hold(3);
    scl_out <= 1'b1;
    hold(3);
    drv <= 1'b1;
    hold(3);
  endtask
  // a read passes 8'hff so the host releases the line; the host always nacks a read byte
  task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(1'b1, ack);
  endtask
endmodule // tsmc_host

/* thermal_sensor_mode_control_test.sv */
// self-checking bench of the thermal sensor control block
`timescale 1ns/1ps
`include "tsmc_map.svh"
module thermal_sensor_mode_control_test;
  localparam int CONV = 32;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic scl, sda, sda_oe, alert_oe, busy, stby;
  logic sda_val, alert_val;
  logic [7:0] dt = 8'h00, it = 8'h00, up = 8'hff, lo = 8'h00;
  logic [7:0] q, cfg, rd;
  logic a0, a1, a2, nak;
  logic [6:0] adr [4] = '{7'h4e, 7'h2a, 7'h2b, 7'h4f};
  int failures = 0;
  int checks = 0;
  int n;
  always #12.5 clk_in = ~clk_in;
  tsmc_host tsmc_host_i (.clk_in(clk_in), .sda_oe_in(sda_oe), .scl_out(scl), .sda_out(sda));
  tsmc_sensor #(.CONV_CYCLES(CONV)) tsmc_sensor_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_val), .sda_oe_out(sda_oe), .alert_n_out(alert_val), .alert_oe_out(alert_oe),
    .diode_temp_in(dt), .internal_temp_in(it), .upper_limit_in(up), .lower_limit_in(lo),
    .conv_busy_out(busy), .standby_out(stby));
  task automatic complete_run;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // arguments are taken at the call, so callers stand 1 ns past the edge where outputs have settled
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic send(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d, input bit wd);
    tsmc_host_i.start();
    tsmc_host_i.xfer({a, 1'b0}, q, a0);
    tsmc_host_i.xfer(c, q, a1);
    a2 = 1'b0;
    if (wd) begin
      tsmc_host_i.xfer(d, q, a2);
    end
    tsmc_host_i.stop();
    nak = a0 | a1 | a2;
    #1;
  endtask
  task automatic read(input logic [7:0] c);
    tsmc_host_i.start();
    tsmc_host_i.xfer(8'h9c, q, a0);
    tsmc_host_i.xfer(c, q, a1);
    tsmc_host_i.start();
    tsmc_host_i.xfer(8'h9d, q, a1);
    tsmc_host_i.xfer(8'hff, rd, a2);
    tsmc_host_i.stop();
    #1;
  endtask
  // counts finished conversions in a fixed window
  task automatic falls(input int cyc);
    logic p;
    n = 0;
    p = busy;
    repeat (cyc) begin
      @(posedge clk_in);
      #1;
      if (p === 1'b1 && busy === 1'b0) n++;
      p = busy;
    end
  endtask
  initial begin
    void'($urandom(26230));
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    for (n = 0; n < 4 * CONV && busy !== 1'b1; n++) @(posedge clk_in);
    if (n == 4 * CONV) begin
      failures++;
      complete_run();
    end
    #1;
    check({7'h00, stby}, 8'h00);
    read(`TSMC_CMD_CFG_RD);
    check(rd, 8'h00);
    falls(3 * (CONV + 1) + 2);
    check({7'h00, n >= 2}, 8'h01);
    adr[3] = 7'($urandom_range(0, 77));
    foreach (adr[k]) begin
      send(adr[k], `TSMC_CMD_CFG_WR, 8'h00, 1'b1);
      check({7'h00, nak}, {7'h00, adr[k] != 7'h4e});
    end
    for (int k = 0; k < 4; k++) begin
      cfg = {2'(k), 6'h00};
      send(7'h4e, `TSMC_CMD_CFG_WR, cfg, 1'b1);
      check({6'h00, stby, busy & stby}, {6'h00, cfg[6], 1'b0});
      read(`TSMC_CMD_CFG_RD);
      check(rd & 8'hc0, cfg);
      // a window of whole periods gives the same count whatever the phase
      falls(3 * (CONV + 1));
      check(8'(n), cfg[6] ? 8'h00 : 8'h03);
      if (cfg[6]) begin
        send(7'h4e, `TSMC_CMD_ONE_SHOT, 8'h00, 1'b0);
        falls(3 * CONV);
        check(8'(n), 8'h01);
      end
    end
    // monitoring stays in auto-convert
    for (int k = 0; k < 8; k++) begin
      cfg = {1'($urandom), 7'h00};
      send(7'h4e, `TSMC_CMD_CFG_WR, cfg, 1'b1);
      @(posedge clk_in);
      dt <= 8'($urandom);
      it <= 8'($urandom);
      up <= 8'($urandom_range(128, 255));
      lo <= 8'($urandom_range(0, 127));
      falls(2 * (CONV + 1) + 4);
      check({7'h00, alert_oe}, {7'h00, !cfg[7] && (dt > up || dt < lo || it > up || it < lo)});
      check({6'h00, sda_val, alert_val}, 8'h00);
      read(`TSMC_CMD_TEMP_RD);
      check(rd, dt);
      read(`TSMC_CMD_ITEMP_RD);
      check(rd, it);
    end
    complete_run();
  end
endmodule // thermal_sensor_mode_control_test
